//--- rtl/dgc_ctrl.sv
// register port, sample path and divided clock of the dac control block
`timescale 1ns/1ps
`default_nettype none
module dgc_ctrl
	import dgc_pkg::*;
#(
	parameter int RES = 16
) (
	input  wire logic                  sys_clk_i,
	input  wire logic                  rstn_i,
	input  wire logic                  spi_cs_n_i,
	input  wire logic                  spi_sck_i,
	input  wire logic                  spi_sdi_i,
	output logic                       spi_sdo_o,
	output logic                       spi_sdo_oe_o,
	input  wire logic                  sample_clk_in_i,
	input  wire logic                  sample_stb_i,
	input  wire logic [RES-1:0]        sample_code_i,
	output logic [RES-1:0]             analog_out_pair_p_o,
	output logic [RES-1:0]             analog_out_pair_n_o,
	output logic [dgc_pkg::TRIM_WIDTH-1:0] full_scale_trim_o,
	output logic [8:0]                 full_scale_den_o,
	output logic                       sample_clk_present_o,
	output logic                       sample_clk_rx_powerdown_o,
	output logic                       divided_clk_out_o,
	output logic                       divided_clk_out_oe_o,
	output logic                       divclk_drive_sel_o,
	output logic                       divclk_term_en_o
);
	import dgc_pkg::*;

	function automatic logic [7:0] reg_read(input logic [6:0] a, input logic [7:0] c, input logic [5:0] t,
		input logic p);
		logic [7:0] v;
		v = 8'h00;
		if (a == ADDR_CLK_CTRL) begin
			v = c;
			v[BIT_CLK_PRESENT] = p;
		end else if (a == ADDR_GAIN_TRIM) begin
			v = {2'b00, t};
		end
		return v;
	endfunction

	// register state
	logic [7:0] clk_ctrl_reg, clk_ctrl_next;
	logic [5:0] trim_reg, trim_next;

	// spi state
	dgc_spi_phase_type phase_reg, phase_next;
	logic       sck_reg, sck_next;
	logic [2:0] bit_reg, bit_next;
	logic       rw_reg, rw_next;
	logic [6:0] addr_reg, addr_next;
	logic [7:0] shin_reg, shin_next;
	logic [7:0] shout_reg, shout_next;
	logic       sdo_reg, sdo_next;
	logic       sck_rise, sck_fall;
	logic [7:0] byte_in;
	logic       present;

	assign sck_rise = !spi_cs_n_i && spi_sck_i && !sck_reg;
	assign sck_fall = !spi_cs_n_i && !spi_sck_i && sck_reg;
	assign byte_in  = {shin_reg[6:0], spi_sdi_i};

	always_comb begin
		clk_ctrl_next = clk_ctrl_reg;
		trim_next     = trim_reg;
		phase_next    = phase_reg;
		sck_next      = spi_sck_i;
		bit_next      = bit_reg;
		rw_next       = rw_reg;
		addr_next     = addr_reg;
		shin_next     = shin_reg;
		shout_next    = shout_reg;
		sdo_next      = sdo_reg;
		if (spi_cs_n_i) begin
			phase_next = SPI_CMD;
			bit_next   = 3'h0;
			sdo_next   = 1'b0;
		end else if (sck_rise) begin
			shin_next = byte_in;
			bit_next  = bit_reg + 3'h1;
			if (bit_reg == 3'h7) begin
				case (phase_reg)
					SPI_CMD: begin
						rw_next    = byte_in[7];
						addr_next  = byte_in[6:0];
						phase_next = SPI_DATA;
						shout_next = reg_read(byte_in[6:0], clk_ctrl_reg, trim_reg, present);
					end
					SPI_DATA: begin
						if (!rw_reg && addr_reg == ADDR_CLK_CTRL) begin
							// status bit and unused bits are not writable
							clk_ctrl_next = byte_in & 8'hF1;
						end
						if (!rw_reg && addr_reg == ADDR_GAIN_TRIM) begin
							trim_next = byte_in[5:0];
						end
						if (addr_reg[4:0] != ADDR_INC_LIMIT) begin
							addr_next = addr_reg + 7'h01;
						end
						shout_next = reg_read(addr_next, clk_ctrl_reg, trim_reg, present);
					end
					default: phase_next = SPI_CMD;
				endcase
			end
		end else if (sck_fall) begin
			if (phase_reg == SPI_DATA && rw_reg) begin
				sdo_next   = shout_reg[7];
				shout_next = {shout_reg[6:0], 1'b0};
			end else begin
				sdo_next = 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			// receiver powered, quarter rate, low drive, no termination
			clk_ctrl_reg <= CLK_CTRL_RESET;
			trim_reg     <= GAIN_TRIM_RESET;
			phase_reg    <= SPI_CMD;
			sck_reg      <= 1'b0;
			bit_reg      <= 3'h0;
			rw_reg       <= 1'b0;
			addr_reg     <= 7'h00;
			shin_reg     <= 8'h00;
			shout_reg    <= 8'h00;
			sdo_reg      <= 1'b0;
		end else begin
			clk_ctrl_reg <= clk_ctrl_next;
			trim_reg     <= trim_next;
			phase_reg    <= phase_next;
			sck_reg      <= sck_next;
			bit_reg      <= bit_next;
			rw_reg       <= rw_next;
			addr_reg     <= addr_next;
			shin_reg     <= shin_next;
			shout_reg    <= shout_next;
			sdo_reg      <= sdo_next;
		end
	end

	assign spi_sdo_o    = sdo_reg;
	assign spi_sdo_oe_o = !spi_cs_n_i;

	// clock detector
	dgc_clk_detect u_detect (
		.sys_clk_i      (sys_clk_i),
		.rstn_i         (rstn_i),
		.clk_level_i    (sample_clk_in_i),
		.rx_powerdown_i (clk_ctrl_reg[BIT_RX_POWERDOWN]),
		.present_o      (present)
	);

	// sample path and divider
	logic [RES-1:0] code_reg, code_next;
	logic           div_reg, div_next;
	logic           dclk_reg, dclk_next;
	logic [8:0]     den_reg, den_next;

	always_comb begin
		code_next = code_reg;
		div_next  = div_reg;
		dclk_next = dclk_reg;
		// denominator computed here; a divider per sample would cost far more
		den_next  = GAIN_NUMERATOR + {{3{trim_reg[5]}}, trim_reg};
		if (!present) begin
			code_next = '0;
			div_next  = 1'b0;
		end else if (sample_stb_i) begin
			code_next = sample_code_i;
			if (!clk_ctrl_reg[BIT_TX_DISABLE]) begin
				if (clk_ctrl_reg[BIT_RATIO_SEL]) begin
					dclk_next = !dclk_reg;
				end else begin
					div_next = !div_reg;
					if (div_reg) begin
						dclk_next = !dclk_reg;
					end
				end
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			code_reg <= '0;
			div_reg  <= 1'b0;
			dclk_reg <= 1'b0;
			den_reg  <= GAIN_NUMERATOR;
		end else begin
			code_reg <= code_next;
			div_reg  <= div_next;
			dclk_reg <= dclk_next;
			den_reg  <= den_next;
		end
	end

	// offset binary steering: zero code gives complementary halves
	assign analog_out_pair_p_o       = {~code_reg[RES-1], code_reg[RES-2:0]};
	assign analog_out_pair_n_o       = ~analog_out_pair_p_o;
	assign full_scale_trim_o         = trim_reg;
	assign full_scale_den_o          = den_reg;
	assign sample_clk_present_o      = present;
	assign sample_clk_rx_powerdown_o = clk_ctrl_reg[BIT_RX_POWERDOWN];
	assign divided_clk_out_o         = dclk_reg;
	assign divided_clk_out_oe_o      = !clk_ctrl_reg[BIT_TX_DISABLE];
	assign divclk_drive_sel_o        = clk_ctrl_reg[BIT_DRIVE_SEL];
	assign divclk_term_en_o          = clk_ctrl_reg[BIT_TERM_EN];

	sequence s_tick;
		present && sample_stb_i && !clk_ctrl_reg[BIT_TX_DISABLE];
	endsequence

	a_midscale_forced: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		!present |=> code_reg == '0)
		else $error("output not held at mid-scale without clock");
	a_sample_update: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		present && sample_stb_i |=> code_reg == $past(sample_code_i))
		else $error("sample code not taken on strobe");
	a_midscale_split: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		code_reg == '0 |-> analog_out_pair_p_o == {1'b1, {(RES-1){1'b0}}}
		&& analog_out_pair_n_o == {1'b0, {(RES-1){1'b1}}})
		else $error("mid-scale code does not split evenly");
	a_gain_denominator: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		$stable(trim_reg) |-> den_reg == 9'(GAIN_NUMERATOR + {{3{trim_reg[5]}}, trim_reg}))
		else $error("gain denominator wrong");
	a_half_rate: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		s_tick ##0 clk_ctrl_reg[BIT_RATIO_SEL] |=> dclk_reg != $past(dclk_reg))
		else $error("half-rate clock did not toggle");
	a_quarter_rate: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		s_tick ##0 (!clk_ctrl_reg[BIT_RATIO_SEL] && !div_reg) |=> $stable(dclk_reg))
		else $error("quarter-rate clock toggled too early");
	a_tx_disable: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		clk_ctrl_reg[BIT_TX_DISABLE] |-> !divided_clk_out_oe_o ##1 $stable(dclk_reg))
		else $error("disabled transmitter still active");
	a_status_readback: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		sck_rise && bit_reg == 3'h7 && phase_reg == SPI_CMD && byte_in[6:0] == ADDR_CLK_CTRL
		|=> shout_reg[BIT_CLK_PRESENT] == $past(present))
		else $error("status bit not loaded from presence flag");
	a_reserved_clear: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		clk_ctrl_reg[3:1] == 3'b000 && trim_reg == full_scale_trim_o)
		else $error("reserved control bits set");
endmodule // dgc_ctrl
`default_nettype wire

//--- rtl/dgc_pkg.sv
// shared constants for the dac gain and clock control block
package dgc_pkg;
	localparam int CLK_PERIOD_NS = 25;

	// register map
	localparam logic [6:0] ADDR_CLK_CTRL   = 7'h02;
	localparam logic [6:0] ADDR_GAIN_TRIM  = 7'h09;
	localparam logic [4:0] ADDR_INC_LIMIT  = 5'h1F;
	localparam logic [7:0] CLK_CTRL_RESET  = 8'h00;
	localparam logic [5:0] GAIN_TRIM_RESET = 6'h00;

	// fields of the clock control register and the gain trim width
	localparam int BIT_RX_POWERDOWN = 0;
	localparam int BIT_CLK_PRESENT  = 1;
	localparam int BIT_TX_DISABLE   = 4;
	localparam int BIT_RATIO_SEL    = 5;
	localparam int BIT_DRIVE_SEL    = 6;
	localparam int BIT_TERM_EN      = 7;
	localparam int TRIM_WIDTH       = 6;

	// gain scaling numerator
	localparam logic [8:0] GAIN_NUMERATOR = 9'h100;

	// clock detector timing
	localparam int DET_WINDOW_NS    = 102400;
	localparam int DET_WIN_CYCLES   = DET_WINDOW_NS / CLK_PERIOD_NS;
	localparam int MIN_CLK_MHZ      = 50;
	localparam int RX_PRESCALE      = 256;
	localparam int DET_MIN_EDGES    = (MIN_CLK_MHZ * DET_WINDOW_NS) / (1000 * RX_PRESCALE);

	typedef enum logic [1:0] {
		SPI_CMD  = 2'b00,
		SPI_DATA = 2'b01
	} dgc_spi_phase_type;
endpackage

//--- rtl/dgc_clk_detect.sv
// sample clock presence detector
`timescale 1ns/1ps
`default_nettype none
module dgc_clk_detect
	import dgc_pkg::*;
#(
	parameter int WIN_CYCLES = dgc_pkg::DET_WIN_CYCLES,
	parameter int MIN_EDGES  = dgc_pkg::DET_MIN_EDGES
) (
	input  wire logic sys_clk_i,
	input  wire logic rstn_i,
	input  wire logic clk_level_i,
	input  wire logic rx_powerdown_i,
	output logic      present_o
);
	import dgc_pkg::*;

	logic        level_reg, level_next;
	logic [15:0] win_reg, win_next;
	logic [15:0] edges_reg, edges_next;
	logic        present_reg, present_next;
	logic        win_end;

	assign win_end = (win_reg == 16'(WIN_CYCLES - 1));

	always_comb begin
		// powered-down receiver sees no edges, so the flag drops at the window end
		level_next   = clk_level_i & ~rx_powerdown_i;
		win_next     = win_end ? 16'h0000 : win_reg + 16'h0001;
		edges_next   = edges_reg;
		present_next = present_reg;
		if (win_end) begin
			present_next = (edges_reg > 16'(MIN_EDGES));
			edges_next   = 16'h0000;
		end else if (level_next && !level_reg && edges_reg != 16'hFFFF) begin
			edges_next = edges_reg + 16'h0001;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			level_reg   <= 1'b0;
			win_reg     <= 16'h0000;
			edges_reg   <= 16'h0000;
			present_reg <= 1'b0;
		end else begin
			level_reg   <= level_next;
			win_reg     <= win_next;
			edges_reg   <= edges_next;
			present_reg <= present_next;
		end
	end

	assign present_o = present_reg;

	a_present_window: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		$changed(present_reg) |-> $past(win_end))
		else $error("presence flag changed outside window end");
	a_present_threshold: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
		win_end |=> present_reg == ($past(edges_reg) > 16'(MIN_EDGES)))
		else $error("presence flag disagrees with edge count");
endmodule // dgc_clk_detect
`default_nettype wire

//--- bench/dgc_host_rx.sv
// host-side receiver model counting divided clock periods
`timescale 1ns/1ps
`default_nettype none
module dgc_host_rx (
	input  wire logic sys_clk_i,
	input  wire logic rstn_i,
	input  wire logic clr_i,
	input  wire logic divided_clk_i,
	input  wire logic oe_i,
	output var int    rises_o
);
	logic last_reg;
	// a released pair looks idle, so no edges while the driver is off
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			last_reg <= 1'b0;
			rises_o  <= 0;
		end else begin
			last_reg <= oe_i & divided_clk_i;
			if (clr_i)
				rises_o <= 0;
			else if (oe_i && divided_clk_i && !last_reg)
				rises_o <= rises_o + 1;
		end
	end
endmodule // dgc_host_rx
`default_nettype wire

//--- bench/tb.sv
// self-checking bench for the dac gain and clock control block
`timescale 1ns/1ps
`default_nettype none
module tb;
	import dgc_pkg::*;
	logic        sys_clk_i, rstn_i, spi_cs_n_i, spi_sck_i, spi_sdi_i;
	logic        sample_clk_in_i, sample_stb_i, clr, sdo, sdo_oe, present, pd;
	logic        divclk, divclk_oe, drive_sel, term_en;
	logic [15:0] sample_code_i, out_p, out_n;
	logic [5:0]  trim, t;
	logic [8:0]  den;
	logic [7:0]  rd;
	int          rises, n_errors, cmp_count, sc_half, sc_cnt, ts;
	logic [5:0]  tl[5] = '{6'h1F, 6'h20, 6'h3F, 6'h01, 6'h00};
	logic [15:0] cl[4] = '{16'h0000, 16'h7FFF, 16'h8000, 16'hFFFF};

	dgc_ctrl #(.RES(16)) dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .spi_cs_n_i(spi_cs_n_i),
		.spi_sck_i(spi_sck_i), .spi_sdi_i(spi_sdi_i), .spi_sdo_o(sdo), .spi_sdo_oe_o(sdo_oe),
		.sample_clk_in_i(sample_clk_in_i), .sample_stb_i(sample_stb_i), .sample_code_i(sample_code_i),
		.analog_out_pair_p_o(out_p), .analog_out_pair_n_o(out_n), .full_scale_trim_o(trim),
		.full_scale_den_o(den), .sample_clk_present_o(present), .sample_clk_rx_powerdown_o(pd),
		.divided_clk_out_o(divclk), .divided_clk_out_oe_o(divclk_oe), .divclk_drive_sel_o(drive_sel),
		.divclk_term_en_o(term_en));
	dgc_host_rx host (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .clr_i(clr), .divided_clk_i(divclk),
		.oe_i(divclk_oe), .rises_o(rises));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk_i);
		#2;
	endtask
	// sck phases of four cycles leave room for edge detect and sdo update
	task automatic spi(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rdat);
		rdat = 8'h00;
		spi_cs_n_i = 1'b0;
		cyc(2);
		chk(sdo_oe, 1'b1);
		for (int i = 15; i >= 0; i--) begin
			spi_sck_i = 1'b0;
			spi_sdi_i = (i > 7) ? cmd[i-8] : wd[i];
			cyc(4);
			if (i < 8)
				rdat[i] = sdo;
			spi_sck_i = 1'b1;
			cyc(4);
		end
		spi_sck_i = 1'b0;
		cyc(4);
		spi_cs_n_i = 1'b1;
		cyc(2);
		chk(sdo_oe, 1'b0);
	endtask
	task automatic wait_flag(input logic v);
		for (int k = 0; k < 20000 && present !== v; k++)
			cyc(1);
		if (present !== v) begin
			n_errors++;
			$display("MISMATCH t=%0t flag wait timed out", $time);
			finish_test();
		end
	endtask
	task automatic put(input int c, input logic live);
		int p;
		sample_code_i = c[15:0];
		sample_stb_i = 1'b1;
		cyc(1);
		sample_stb_i = 1'b0;
		p = live ? ((c >= 32768) ? c - 65536 : c) + 32768 : 32768;
		chk(out_p, p);
		chk(out_n, 65535 - p);
		cyc(1);
	endtask
	task automatic divcheck(input logic [7:0] ctl, input int exp);
		spi({1'b0, ADDR_CLK_CTRL}, ctl, rd);
		chk(rd, 8'h00);
		chk(divclk_oe, !ctl[BIT_TX_DISABLE]);
		chk(drive_sel, ctl[BIT_DRIVE_SEL]);
		chk(term_en, ctl[BIT_TERM_EN]);
		spi({1'b1, ADDR_CLK_CTRL}, 8'h00, rd);
		chk(rd, ctl | 8'h02);
		clr = 1'b1;
		cyc(1);
		clr = 1'b0;
		for (int i = 0; i < 8; i++)
			put($urandom_range(0, 65535), 1'b1);
		chk(rises, exp);
	endtask

	initial begin
		sys_clk_i = 1'b0;
		forever #12.5 sys_clk_i = ~sys_clk_i;
	end
	initial begin
		sample_clk_in_i = 1'b0;
		sc_cnt = 0;
		forever begin
			@(posedge sys_clk_i);
			sc_cnt++;
			if (sc_half != 0 && sc_cnt >= sc_half) begin
				sc_cnt = 0;
				#2 sample_clk_in_i = ~sample_clk_in_i;
			end
		end
	end
	initial begin
		rstn_i = 1'b0;
		spi_cs_n_i = 1'b1;
		spi_sck_i = 1'b0;
		spi_sdi_i = 1'b0;
		sample_stb_i = 1'b0;
		sample_code_i = 16'h0000;
		clr = 1'b0;
		sc_half = 0;
		n_errors = 0;
		cmp_count = 0;
		void'($urandom(32'hD948));
		cyc(8);
		rstn_i = 1'b1;
		cyc(2);
		chk({trim, den, present, pd, divclk_oe, drive_sel, term_en}, {6'h00, 9'h100, 5'b00100});
		put(16'h1234, 1'b0);
		spi({1'b1, ADDR_GAIN_TRIM}, 8'h00, rd);
		chk(rd, 8'h00);
		sc_half = 3;
		wait_flag(1'b1);
		for (int i = 0; i < 6; i++) begin
			t = (i < 5) ? tl[i] : 6'($urandom_range(0, 63));
			ts = (t >= 32) ? int'(t) - 64 : int'(t);
			spi({1'b0, ADDR_GAIN_TRIM}, {2'b00, t}, rd);
			chk(trim, t);
			chk(den, 256 + ts);
			spi({1'b1, ADDR_GAIN_TRIM}, 8'h00, rd);
			chk(rd, {2'b00, t});
		end
		for (int i = 0; i < 10; i++)
			put((i < 4) ? int'(cl[i]) : $urandom_range(0, 65535), 1'b1);
		divcheck(8'h00, 2);
		divcheck(8'h20, 4);
		divcheck(8'hE0, 4);
		divcheck(8'h10, 0);
		spi({1'b0, 7'h05}, 8'hFF, rd);
		spi({1'b1, 7'h05}, 8'h00, rd);
		chk(rd, 8'h00);
		spi({1'b0, ADDR_CLK_CTRL}, 8'h01, rd);
		chk(pd, 1'b1);
		wait_flag(1'b0);
		put($urandom_range(0, 65535), 1'b0);
		spi({1'b0, ADDR_CLK_CTRL}, 8'h00, rd);
		wait_flag(1'b1);
		sc_half = 400;
		wait_flag(1'b0);
		put(16'h7FFF, 1'b0);
		finish_test();
	end
endmodule // tb
`default_nettype wire
